// ---- hw/pbw_pkg.sv ----
// Constants and types for the peripheral bus wait logic.
// Assumes one CPU clock domain; the peripheral side is asynchronous.
package pbw_pkg;
    // Register selector codes on the access port
    localparam logic [3:0] PBW_SEL_NONE = 4'h0;
    localparam logic [3:0] PBW_SEL_UART_RX_ERROR_STATUS = 4'h1;
    localparam logic [3:0] PBW_SEL_I2C_BUS_STATUS = 4'h2;
    localparam logic [3:0] PBW_SEL_ADC_MODE_CTRL = 4'h3;
    localparam logic [3:0] PBW_SEL_ADC_CHANNEL_SELECT = 4'h4;
    localparam logic [3:0] PBW_SEL_ADC_PORT_CONFIG_LOW = 4'h5;
    localparam logic [3:0] PBW_SEL_ADC_PORT_CONFIG_HIGH = 4'h6;
    localparam logic [3:0] PBW_SEL_ADC_RESULT_FULL = 4'h7;
    localparam logic [3:0] PBW_SEL_ADC_RESULT_UPPER = 4'h8;
    // Fixed wait for status reads, in CPU clocks
    localparam logic [7:0] PBW_FIXED_WAIT = 8'h01;
    // Formula constants: wait = 2 * fcpu / fad + 1
    localparam int PBW_WAIT_MULT = 2;
    localparam logic [7:0] PBW_WAIT_ADD = 8'h01;
    // Width of the frequency inputs
    localparam int PBW_FREQ_W = 16;
    typedef enum logic [1:0]
    {
        PBW_IDLE = 2'b00,
        PBW_CALC = 2'b01,
        PBW_WAIT = 2'b10,
        PBW_SYNC = 2'b11
    } pbw_state_type;
endpackage : pbw_pkg

// ---- hw/pbw_sync.sv ----
// Two-flop synchroniser for a single level.
// Assumes the input comes from an unrelated clock domain.
`timescale 1ns/100ps
`default_nettype none
module pbw_sync
(
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic async_in,
    output logic sync_out
);
    logic stage_one;

    // First stage feeds only the second stage
    always_ff @(posedge clock_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            stage_one <= 1'b0;
            sync_out <= 1'b0;
        end
        else
        begin
            stage_one <= async_in;
            sync_out <= stage_one;
        end
    end
endmodule : pbw_sync
`default_nettype wire

// ---- hw/pbw_wait_logic.sv ----
// Wait-request logic between the CPU bus and the asynchronous peripheral bus.
// Assumes the CPU presents one access at a time and holds it while wait_out is high,
// and that the peripheral side toggles periph_done_toggle_in once per finished transfer.
`timescale 1ns/100ps
`default_nettype none
module pbw_wait_logic
    import pbw_pkg::*;
#(
    parameter int FREQ_W = PBW_FREQ_W
)
(
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic access_valid_in,
    input wire logic access_write_in,
    input wire logic [3:0] access_sel_in,
    input wire logic [FREQ_W-1:0] cpu_freq_in,
    input wire logic [FREQ_W-1:0] adc_freq_in,
    input wire logic periph_done_toggle_in,
    output logic wait_out,
    output logic periph_req_toggle_out,
    output logic [7:0] wait_count_out
);
    // Stall state and wait bookkeeping
    pbw_state_type state;
    pbw_state_type next_state;
    logic [7:0] count;
    logic [7:0] next_count;
    logic [7:0] target;
    logic done_sync;
    logic done_seen;
    logic [FREQ_W+1:0] quotient;
    logic [FREQ_W+1:0] remainder_x2;

    // One hit line per waiting register; the direction is looked at below,
    // since the same register may stall on a read and pass on a write
    wire hit_uart_rx_error_status = access_sel_in == PBW_SEL_UART_RX_ERROR_STATUS;
    wire hit_i2c_bus_status = access_sel_in == PBW_SEL_I2C_BUS_STATUS;
    wire hit_adc_mode_ctrl = access_sel_in == PBW_SEL_ADC_MODE_CTRL;
    wire hit_adc_channel_select = access_sel_in == PBW_SEL_ADC_CHANNEL_SELECT;
    wire hit_adc_port_config_low = access_sel_in == PBW_SEL_ADC_PORT_CONFIG_LOW;
    wire hit_adc_port_config_high = access_sel_in == PBW_SEL_ADC_PORT_CONFIG_HIGH;
    wire hit_adc_result_full = access_sel_in == PBW_SEL_ADC_RESULT_FULL;
    wire hit_adc_result_upper = access_sel_in == PBW_SEL_ADC_RESULT_UPPER;

    // Direction of the access now on the bus
    wire is_read = access_valid_in && !access_write_in;
    wire is_write = access_valid_in && access_write_in;

    // Status registers conflict only on a read; writing them never stalls
    wire is_status_hit = hit_uart_rx_error_status || hit_i2c_bus_status;
    wire is_status_read = is_read && is_status_hit;

    // A/D set-up registers conflict on a write, result registers on a read
    wire is_adc_setup_hit = hit_adc_mode_ctrl || hit_adc_channel_select ||
        hit_adc_port_config_low || hit_adc_port_config_high;
    wire is_adc_result_hit = hit_adc_result_full || hit_adc_result_upper;
    wire is_adc_write = is_write && is_adc_setup_hit;
    wire is_adc_read = is_read && is_adc_result_hit;
    wire is_adc_access = is_adc_write || is_adc_read;

    // Every other register, and the wrong direction, passes with no stall
    wire is_conflict = is_status_read || is_adc_access;

    // Wait = 2*fcpu/fad + 1, both in the same units; a zero A/D clock
    // would never finish, so it is treated as the smallest divisor.
    wire [FREQ_W+1:0] numer = (FREQ_W+2)'(PBW_WAIT_MULT) * {2'b00, cpu_freq_in};
    wire [FREQ_W+1:0] denom = (adc_freq_in == '0) ? (FREQ_W+2)'(1) : {2'b00, adc_freq_in};
    assign quotient = numer / denom;
    assign remainder_x2 = (numer % denom) << 1;
    // Fraction above one half rounds up, one half or less is dropped
    wire round_up = remainder_x2 > denom;
    // Faster CPU or slower A/D clock lengthens the wait through this ratio
    wire [FREQ_W+1:0] raw_wait = quotient + (FREQ_W+2)'(round_up)
        + (FREQ_W+2)'(PBW_WAIT_ADD);
    // Saturate rather than wrap so an extreme ratio never shortens the stall
    wire [7:0] adc_wait = (raw_wait > (FREQ_W+2)'(8'hff)) ? 8'hff : raw_wait[7:0];
    wire [7:0] next_target = is_status_read ? PBW_FIXED_WAIT : adc_wait;

    // Completion of the peripheral transfer arrives on the peripheral clock
    pbw_sync u_done_sync
    (
        .clock_in(clock_in),
        .reset_in(reset_in),
        .async_in(periph_done_toggle_in),
        .sync_out(done_sync)
    );
    // A finished transfer stays pending until the release that it allows, so a
    // peripheral that answers while the count still runs is never lost; the
    // answer can only come after the request, so nothing is pending while idle
    wire done_event = done_sync != done_seen;
    // In WAIT the counter plus one gives the stalled clocks before the present one
    wire count_expired = (count + 8'h01) >= target;

    // Next state: count the wait in CPU clocks, then make sure the
    // peripheral side really finished before letting the CPU go
    always_comb
    begin
        next_state = state;
        case (state)
            PBW_IDLE:
            begin
                if (is_conflict)
                begin
                    next_state = PBW_CALC;
                end
            end
            PBW_CALC:
            begin
                next_state = PBW_WAIT;
            end
            PBW_WAIT:
            begin
                if (count_expired)
                begin
                    next_state = (done_event) ? PBW_IDLE : PBW_SYNC;
                end
            end
            PBW_SYNC:
            begin
                if (done_event)
                begin
                    next_state = PBW_IDLE;
                end
            end
            default:
            begin
                next_state = PBW_IDLE;
            end
        endcase
    end

    // Stall is combinational so the CPU holds off in the access cycle itself;
    // the access cycle counts as the first wait clock.
    assign wait_out = (state == PBW_IDLE) ? is_conflict : (next_state != PBW_IDLE);

    // Launch on the edge that ends the access cycle; release on the edge that
    // ends the first cycle in which the stall is already low, which is also
    // the edge at which the CPU takes its data
    wire is_stalled = state != PBW_IDLE;
    wire launch_now = !is_stalled && is_conflict;
    wire release_now = is_stalled && (next_state == PBW_IDLE);

    // Every stalled clock is counted, SYNC included, so the figure handed out is
    // the whole stall; saturating keeps a very long stall from reading as short
    wire count_full = count == 8'hff;
    wire [7:0] count_step = count_full ? count : count + 8'h01;
    assign next_count = launch_now ? 8'h00 :
        is_stalled ? count_step : count;

    // State register; all four codes are in use, so the default branch above
    // only matters for an unknown value in simulation
    always_ff @(posedge clock_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            state <= PBW_IDLE;
        end
        else
        begin
            state <= next_state;
        end
    end

    // Wait counter in CPU clocks; it holds its last value while idle, which
    // costs nothing since every launch clears it
    always_ff @(posedge clock_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            count <= 8'h00;
        end
        else
        begin
            count <= next_count;
        end
    end

    // Target and peripheral request are taken once, as the access is accepted;
    // a second access seen during a stall is ignored, since the CPU is held and
    // cannot have issued it
    always_ff @(posedge clock_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            target <= 8'h00;
            periph_req_toggle_out <= 1'b0;
        end
        else if (launch_now)
        begin
            target <= next_target;
            periph_req_toggle_out <= !periph_req_toggle_out;
        end
    end

    // The completion is consumed only by the release that it allows, so each
    // request pairs with exactly one answer even when the answer comes early
    always_ff @(posedge clock_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            done_seen <= 1'b0;
        end
        else if (release_now)
        begin
            done_seen <= done_sync;
        end
    end

    // Length of the last stall, held until the next release; in the release
    // cycle next_count already equals the number of clocks that were stalled
    always_ff @(posedge clock_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            wait_count_out <= 8'h00;
        end
        else if (release_now)
        begin
            wait_count_out <= next_count;
        end
    end
endmodule : pbw_wait_logic
`default_nettype wire

// ---- testbench/pbw_monitor.sv ----
// Port assertions for the wait logic.
// Assumes it is bound to every pbw_wait_logic.
`timescale 1ns/100ps
`default_nettype none
module pbw_monitor
(
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic access_valid_in,
    input wire logic access_write_in,
    input wire logic [3:0] access_sel_in,
    input wire logic wait_out,
    input wire logic periph_req_toggle_out,
    input wire logic [7:0] wait_count_out
);
    // Listed register in its waiting direction
    wire logic lst = access_valid_in & (access_write_in ? access_sel_in inside {[4'h3:4'h6]}
        : access_sel_in inside {4'h1, 4'h2, 4'h7, 4'h8});
    logic [8:0] run;
    // Stall length so far, held against the reported count
    always_ff @(posedge clock_in or posedge reset_in)
        run <= reset_in ? 9'h0 : (wait_out ? run + 9'h1 : 9'h0);
    default clocking mc @(posedge clock_in); endclocking
    default disable iff (reset_in);
    cause_a: assert property (wait_out |-> lst) else $error("stray stall");
    start_a: assert property ($rose(access_valid_in) & lst |-> wait_out)
        else $error("no stall");
    launch_a: assert property ($rose(wait_out) |=> $changed(periph_req_toggle_out))
        else $error("no request");
    req_only_a: assert property ($changed(periph_req_toggle_out) |-> $past(wait_out))
        else $error("stray request");
    sync_hold_a: assert property ($rose(wait_out) |-> wait_out[*3])
        else $error("early release");
    stall_bound_a: assert property (wait_out |-> ##[1:300] !wait_out)
        else $error("stall hangs");
    count_match_a: assert property ($fell(wait_out)
        |=> {1'b0, wait_count_out} == $past(run)) else $error("bad count");
    count_hold_a: assert property ($changed(wait_count_out)
        |-> $past(wait_out, 2) && !$past(wait_out)) else $error("count moved");
    cover property ($fell(wait_out) & !access_write_in);
    cover property ($fell(wait_out) & run > 9'h9);
    cover property (access_valid_in & !lst);
endmodule : pbw_monitor
bind pbw_wait_logic pbw_monitor u_pbw_monitor (.clock_in(clock_in), .reset_in(reset_in),
    .access_valid_in(access_valid_in), .access_write_in(access_write_in),
    .access_sel_in(access_sel_in), .wait_out(wait_out),
    .periph_req_toggle_out(periph_req_toggle_out), .wait_count_out(wait_count_out));
`default_nettype wire

// ---- testbench/pbw_periph_model.sv ----
// Far-side model: finishes each requested transfer after a set delay.
// Assumes its clock keeps running while a transfer is pending.
`timescale 1ns/100ps
`default_nettype none
module pbw_periph_model
(
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic [3:0] delay_in,
    input wire logic req_in,
    output logic done_out
);
    logic [3:0] left;
    // Load delay while idle, count down, then answer; never drops a request
    always_ff @(posedge clock_in or posedge reset_in)
        {left, done_out} <= reset_in ? 5'h00 : (req_in == done_out) ? {delay_in, done_out}
            : (left == 4'h0) ? {left, ~done_out} : {left - 4'h1, done_out};
endmodule : pbw_periph_model
`default_nettype wire

// ---- testbench/peripheral_bus_wait_logic_bench.sv ----
// Self-checking bench for the peripheral bus wait logic.
// Assumes the bound monitor and the far-side model.
`timescale 1ns/100ps
`default_nettype none
module peripheral_bus_wait_logic_bench;
    logic clock_in, reset_in = 1'b1, access_valid_in = 1'b0, access_write_in = 1'b0;
    logic periph_done_toggle_in, wait_out, periph_req_toggle_out;
    logic [3:0] access_sel_in = 4'h0, dly = 4'h0;
    logic [15:0] cpu_freq_in = 16'h1, adc_freq_in = 16'h1;
    logic [7:0] wait_count_out;
    int errors = 0, samples_checked = 0;
    pbw_wait_logic u_dut (.clock_in(clock_in), .reset_in(reset_in),
        .access_valid_in(access_valid_in), .access_write_in(access_write_in),
        .access_sel_in(access_sel_in), .cpu_freq_in(cpu_freq_in), .adc_freq_in(adc_freq_in),
        .periph_done_toggle_in(periph_done_toggle_in), .wait_out(wait_out),
        .periph_req_toggle_out(periph_req_toggle_out), .wait_count_out(wait_count_out));
    pbw_periph_model u_far (.clock_in(clock_in), .reset_in(reset_in), .delay_in(dly),
        .req_in(periph_req_toggle_out), .done_out(periph_done_toggle_in));
    initial
    begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end
    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
        samples_checked++;
        errors += int'(seen !== exp);
        if (seen !== exp)
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    endtask : check
    // Rounded A/D wait, capped at what the count port can hold
    function automatic logic [17:0] ad_wait(input logic [17:0] n, input logic [17:0] d);
        logic [17:0] q = n / d + 18'((n % d) > (d >> 1)) + 18'h1;
        return q > 18'hff ? 18'hff : q;
    endfunction : ad_wait
    // One access held through its stall; kind 0 none, 1 status, 2 A/D
    task automatic access(input logic [3:0] s, input logic w, input int kind,
        input logic [15:0] c, input logic [15:0] a, input logic [3:0] d);
        int n;
        logic [17:0] exp;
        exp = kind < 2 ? 18'(kind) : ad_wait({1'b0, c, 1'b0}, a == 16'h0 ? 18'h1 : 18'(a));
        @(posedge clock_in);
        {access_valid_in, access_write_in, access_sel_in, cpu_freq_in, adc_freq_in, dly} <=
            {1'b1, w, s, c, a, d};
        @(negedge clock_in);
        for (n = 0; wait_out === 1'b1 && n < 400; n++)
            @(negedge clock_in);
        @(posedge clock_in);
        access_valid_in <= 1'b0;
        @(negedge clock_in);
        check(18'(kind == 0 ? n : int'(n >= int'(exp))), 18'(kind != 0));
        if (kind != 0)
            check(18'(wait_count_out), 18'(n));
        if (exp > 18'h9)
            check(18'(n), exp);
        $display("access %h ended after %0d waits", s, n);
    endtask : access
    initial
    begin
        void'($urandom(32'hca2f1800));
        repeat (6) @(posedge clock_in);
        reset_in <= 1'b0;
        for (int i = 0; i < 4; i++)
            access(4'(1 + i % 2), 1'b0, 1, 16'h1, 16'h1, 4'(5 * i));
        for (int i = 0; i < 16; i++)
            access(4'(i), i inside {1, 2, 7, 8} || i > 8, 0, 16'h1, 16'h1, 4'h0);
        access(4'h8, 1'b0, 2, 16'hffff, 16'h0, 4'h2);
        for (int i = 0; i < 30; i++)
            access(4'(3 + i % 6), i % 6 < 4, 2, 16'($urandom_range(64, 1)),
                16'($urandom_range(12, 1)), 4'($urandom_range(3)));
        tally_and_finish();
    end
    // Hang guard, far beyond the expected run
    initial
    begin
        #200000 errors++;
        tally_and_finish();
    end
    task automatic tally_and_finish();
        $display("compared %0d, mismatched %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : tally_and_finish
endmodule : peripheral_bus_wait_logic_bench
`default_nettype wire
